//--- rtl/host_port_pkg.sv
// Constants for the asynchronous parallel host register port.
// Assumes one 10 MHz system clock; all host pins arrive synchronous to it.
package host_port_pkg;

  // ----------------------------------------------------------------
  // Bus shape
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORDS = 1024;
  localparam int unsigned IRQ_W = 8;

  // ----------------------------------------------------------------
  // Register word addresses reached through the port
  // ----------------------------------------------------------------
  localparam logic [9:0] IRQ_STATUS_ADDR = 10'h000;
  localparam logic [9:0] IRQ_ENABLE_ADDR = 10'h001;
  localparam logic [9:0] PORT_CTRL_ADDR = 10'h002;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_DRIVE_HIGH_BIT = 0;
  localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
  localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
  localparam logic CTRL_DRIVE_HIGH_RST = 1'b0;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [1:0] BE_LOW = 2'b01;
  localparam logic [1:0] BE_HIGH = 2'b10;
  localparam logic [1:0] BE_BOTH = 2'b11;

  // ----------------------------------------------------------------
  // Access sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RD_FETCH = 5'b00010,
    ST_RD_SHOW = 5'b00100,
    ST_WR_HOLD = 5'b01000,
    ST_WR_COMMIT = 5'b10000
  } access_state_e;

endpackage : host_port_pkg

//--- rtl/host_reg_mem.sv
// General register storage behind the host port: 1024 words of 16 bits.
// Assumes one write port with byte enables and one registered read port.
`timescale 1ns/1ps
`default_nettype none
module host_reg_mem
(
  // Clock and clear
  input wire logic clk,
  input wire logic clr,
  // Write port
  input wire logic wr_en,
  input wire logic [9:0] wr_addr,
  input wire logic [1:0] wr_be,
  input wire logic [15:0] wr_data,
  // Read port
  input wire logic [9:0] rd_addr,
  output logic [15:0] rd_data
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Per-byte valid bits stand in for a clear of the whole array, which
  // a single clear cycle could not reach
  logic [15:0] mem [0:host_port_pkg::WORDS-1];
  logic [host_port_pkg::WORDS-1:0] vld_lo_q;
  logic [host_port_pkg::WORDS-1:0] vld_hi_q;
  logic [15:0] rd_data_q;

  always_ff @(posedge clk)
  begin
    if (wr_en && wr_be[0])
    begin
      mem[wr_addr][7:0] <= wr_data[7:0];
    end
    if (wr_en && wr_be[1])
    begin
      mem[wr_addr][15:8] <= wr_data[15:8];
    end
  end

  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      vld_lo_q <= '0;
      vld_hi_q <= '0;
      rd_data_q <= host_port_pkg::WORD_RST;
    end
    else
    begin
      if (wr_en && wr_be[0])
      begin
        vld_lo_q[wr_addr] <= 1'b1;
      end
      if (wr_en && wr_be[1])
      begin
        vld_hi_q[wr_addr] <= 1'b1;
      end
      rd_data_q <= {vld_hi_q[rd_addr] ? mem[rd_addr][15:8] : 8'h00,
                    vld_lo_q[rd_addr] ? mem[rd_addr][7:0] : 8'h00};
    end
  end

  assign rd_data = rd_data_q;

endmodule : host_reg_mem
`default_nettype wire

//--- rtl/async_host_register_port.sv
// Parallel host register port: strobe decode, address latch, lane mapping,
// ready handshake and the interrupt pin. Assumes host pins are synchronous
// to clk and that tri-state resolution happens outside this module.
//
// How it works
// - Data bus released in reset or deselect
// - Upper data byte never driven when narrow
// - Address pins 10..1 pick one word
// - Narrow: lowest address bit picks byte
// - Wide: lowest address bit swaps lanes
// - Latch enable high passes, low holds
// - Ready low once access can complete
// - Ready undriven while deselected
// - Interrupt low when enabled event pending
// - Idle interrupt drive programmable, default off
// - Sources disabled by reset until enabled
// - Interrupt released while reset pin low
// - Mode and width pins pick behaviour
// - Reset pin clears port registers
`timescale 1ns/1ps
`default_nettype none
module async_host_register_port
(
  // Clock and resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rst_n,
  // Static straps
  input wire logic mode,
  input wire logic width,
  // Address and control pins
  input wire logic [9:0] addr,
  input wire logic byte_lane_swap,
  input wire logic ale,
  input wire logic cs_n,
  input wire logic rd_n_data_strobe_n,
  input wire logic wr_n_dir,
  // Data bus
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic [15:0] data_oe,
  // Ready handshake
  output logic ready_n,
  output logic ready_oe,
  // Interrupt
  input wire logic [7:0] irq_event,
  output logic irq_n,
  output logic irq_oe
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] swap_lanes(input logic [15:0] w, input logic sw);
    swap_lanes = sw ? {w[7:0], w[15:8]} : w;
  endfunction : swap_lanes

  function automatic logic [15:0] read_lanes(input logic [15:0] w, input logic wide,
                                             input logic a0);
    read_lanes = wide ? swap_lanes(w, a0) : {8'h00, a0 ? w[15:8] : w[7:0]};
  endfunction : read_lanes

  // ----------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------
  logic clr;
  logic sel;
  logic rd_act;
  logic wr_act;
  logic [9:0] addr_lat_q;
  logic [9:0] addr_lat_d;
  logic [9:0] addr_eff;

  assign clr = sys_rst | ~rst_n;
  assign sel = ~cs_n & rst_n;
  assign rd_act = sel & ~rd_n_data_strobe_n & (mode ? wr_n_dir : 1'b1);
  assign wr_act = sel & (mode ? (~rd_n_data_strobe_n & ~wr_n_dir) : ~wr_n_dir);

  always_comb
  begin
    addr_lat_d = ale ? addr : addr_lat_q;
  end

  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      addr_lat_q <= '0;
    end
    else
    begin
      addr_lat_q <= addr_lat_d;
    end
  end

  assign addr_eff = ale ? addr : addr_lat_q;

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  host_port_pkg::access_state_e st_q;
  host_port_pkg::access_state_e st_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [15:0] wdata_q;
  logic [15:0] wdata_d;
  logic [1:0] wbe_q;
  logic [1:0] wbe_d;
  logic [9:0] waddr_q;
  logic [9:0] waddr_d;
  logic [15:0] mem_rdata;
  logic [15:0] word_rd;
  logic commit;

  assign commit = (st_q == host_port_pkg::ST_WR_COMMIT);

  always_comb
  begin
    st_d = st_q;
    rdata_d = rdata_q;
    wdata_d = wdata_q;
    wbe_d = wbe_q;
    waddr_d = waddr_q;
    // Address and data are taken only while the write strobe stands, so a
    // host may move them on the very edge that releases the strobe
    if (wr_act && (st_q == host_port_pkg::ST_IDLE || st_q == host_port_pkg::ST_WR_HOLD))
    begin
      waddr_d = addr_eff;
      wdata_d = width ? swap_lanes(data_in, byte_lane_swap)
                      : {data_in[7:0], data_in[7:0]};
      wbe_d = width ? host_port_pkg::BE_BOTH
                    : (byte_lane_swap ? host_port_pkg::BE_HIGH : host_port_pkg::BE_LOW);
    end
    unique case (st_q)
      host_port_pkg::ST_IDLE:
      begin
        if (rd_act)
        begin
          st_d = host_port_pkg::ST_RD_FETCH;
        end
        else if (wr_act)
        begin
          st_d = host_port_pkg::ST_WR_HOLD;
        end
      end
      host_port_pkg::ST_RD_FETCH:
      begin
        rdata_d = read_lanes(word_rd, width, byte_lane_swap);
        st_d = rd_act ? host_port_pkg::ST_RD_SHOW : host_port_pkg::ST_IDLE;
      end
      host_port_pkg::ST_RD_SHOW:
      begin
        if (!rd_act)
        begin
          st_d = host_port_pkg::ST_IDLE;
        end
      end
      host_port_pkg::ST_WR_HOLD:
      begin
        if (!wr_act)
        begin
          st_d = host_port_pkg::ST_WR_COMMIT;
        end
      end
      host_port_pkg::ST_WR_COMMIT:
      begin
        st_d = host_port_pkg::ST_IDLE;
      end
      default:
      begin
        st_d = host_port_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      st_q <= host_port_pkg::ST_IDLE;
      rdata_q <= host_port_pkg::WORD_RST;
      wdata_q <= host_port_pkg::WORD_RST;
      wbe_q <= host_port_pkg::BE_BOTH;
      waddr_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      rdata_q <= rdata_d;
      wdata_q <= wdata_d;
      wbe_q <= wbe_d;
      waddr_q <= waddr_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt registers
  // ----------------------------------------------------------------
  logic [7:0] irq_status_q;
  logic [7:0] irq_status_d;
  logic [7:0] irq_enable_q;
  logic [7:0] irq_enable_d;
  logic drive_high_q;
  logic drive_high_d;
  logic irq_active;
  logic wr_status;

  assign wr_status = commit & (waddr_q == host_port_pkg::IRQ_STATUS_ADDR);

  always_comb
  begin
    // Write one to clear; a new event in the same cycle keeps its bit
    irq_status_d = (irq_status_q & ~(wr_status ? wdata_q[7:0] : 8'h00)) | irq_event;
    irq_enable_d = irq_enable_q;
    drive_high_d = drive_high_q;
    if (commit && waddr_q == host_port_pkg::IRQ_ENABLE_ADDR && wbe_q[0])
    begin
      irq_enable_d = wdata_q[7:0];
    end
    if (commit && waddr_q == host_port_pkg::PORT_CTRL_ADDR && wbe_q[0])
    begin
      drive_high_d = wdata_q[host_port_pkg::CTRL_DRIVE_HIGH_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      irq_status_q <= host_port_pkg::IRQ_STATUS_RST;
      irq_enable_q <= host_port_pkg::IRQ_ENABLE_RST;
      drive_high_q <= host_port_pkg::CTRL_DRIVE_HIGH_RST;
    end
    else
    begin
      irq_status_q <= irq_status_d;
      irq_enable_q <= irq_enable_d;
      drive_high_q <= drive_high_d;
    end
  end

  assign irq_active = |(irq_status_q & irq_enable_q);

  // ----------------------------------------------------------------
  // Storage and read mux
  // ----------------------------------------------------------------
  // Special addresses are read a cycle late from the same registered address
  logic [9:0] rd_addr_q;

  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      rd_addr_q <= '0;
    end
    else
    begin
      rd_addr_q <= addr_eff;
    end
  end

  always_comb
  begin
    unique case (rd_addr_q)
      host_port_pkg::IRQ_STATUS_ADDR: word_rd = {8'h00, irq_status_q};
      host_port_pkg::IRQ_ENABLE_ADDR: word_rd = {8'h00, irq_enable_q};
      host_port_pkg::PORT_CTRL_ADDR: word_rd = {15'h0000, drive_high_q};
      default: word_rd = mem_rdata;
    endcase
  end

  host_reg_mem u_mem
  (
    .clk(clk),
    .clr(clr),
    .wr_en(commit),
    .wr_addr(waddr_q),
    .wr_be(wbe_q),
    .wr_data(wdata_q),
    .rd_addr(addr_eff),
    .rd_data(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic show;
  logic busy_ok;

  assign show = (st_q == host_port_pkg::ST_RD_SHOW) & rd_act;
  assign busy_ok = (st_q == host_port_pkg::ST_RD_SHOW) | (st_q == host_port_pkg::ST_WR_HOLD);
  assign data_out = rdata_q;
  assign data_oe = {{8{show & width}}, {8{show}}};
  assign ready_n = ~busy_ok;
  assign ready_oe = sel;
  assign irq_n = ~irq_active;
  assign irq_oe = rst_n & (irq_active | drive_high_q);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence rd_start_s;
    (st_q == host_port_pkg::ST_IDLE) && rd_act;
  endsequence

  sequence rd_show_s;
    (st_q == host_port_pkg::ST_RD_SHOW) && !ready_n && (!rd_act || data_oe[7:0] == 8'hff);
  endsequence

  bus_release_a: assert property ((cs_n || !rst_n) |-> data_oe == 16'h0000)
    else $error("data bus driven while deselected or in reset");
  narrow_upper_a: assert property (!width |-> data_oe[15:8] == 8'h00)
    else $error("upper byte driven in narrow mode");
  read_timing_a: assert property (rd_start_s ##1 rd_act |=> rd_show_s)
    else $error("read data not shown two cycles after strobe");
  ready_low_a: assert property (show |-> !ready_n && ready_oe)
    else $error("ready not asserted while showing read data");
  ready_release_a: assert property (cs_n |-> !ready_oe)
    else $error("ready driven while deselected");
  irq_low_a: assert property (rst_n && !commit && (|(irq_event & irq_enable_q))
                              |=> !irq_n)
    else $error("interrupt not driven for enabled event");
  irq_reset_a: assert property (!rst_n |=> irq_enable_q == 8'h00 && !irq_oe)
    else $error("interrupt sources not disabled by reset");
  irq_idle_a: assert property (!irq_active && rst_n |-> irq_oe == drive_high_q)
    else $error("idle interrupt drive wrong");
  write_commit_a: assert property ((st_q == host_port_pkg::ST_WR_HOLD) && !wr_act
                                   |=> commit ##1 (st_q == host_port_pkg::ST_IDLE))
    else $error("write not committed on strobe release");
  latch_hold_a: assert property (!ale && !$past(ale) && !$past(clr)
                                 |-> addr_eff == $past(addr_eff))
    else $error("latched address moved while latch enable low");

endmodule : async_host_register_port
`default_nettype wire

//--- tb/host_model.sv
// Host processor model for the parallel register port.
// Assumes its pins change just after clk rising edges; the bus is resolved outside.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  // Clock and straps
  input wire logic clk,
  input wire logic mode,
  input wire logic width,
  // Port returns
  input wire logic [15:0] bus,
  input wire logic [15:0] bus_oe,
  input wire logic ready_n,
  input wire logic ready_oe,
  // Host pins
  output logic [9:0] addr,
  output logic byte_lane_swap,
  output logic ale,
  output logic cs_n,
  output logic strb_n,
  output logic wr_n_dir,
  output logic [15:0] host_d,
  output logic [15:0] host_oe
);
  initial
  begin
    addr = 10'h000;
    byte_lane_swap = 1'b0;
    ale = 1'b1;
    cs_n = 1'b1;
    strb_n = 1'b1;
    wr_n_dir = 1'b1;
    host_d = 16'h0000;
    host_oe = 16'h0000;
  end
  // ----------------------------------------------------------------
  // One access, held until ready is seen low
  // ----------------------------------------------------------------
  task automatic access(input logic wr, input logic [9:0] a, input logic a0,
    input logic [15:0] d, input logic muxed, output logic [15:0] q,
    output logic [15:0] q_oe, output int lat);
    @(posedge clk);
    addr <= a;
    byte_lane_swap <= a0;
    if (muxed)
    begin
      @(posedge clk);
      ale <= 1'b0;
      @(posedge clk);
      addr <= ~a;
    end
    cs_n <= 1'b0;
    strb_n <= !(mode || !wr);
    wr_n_dir <= !wr;
    host_d <= d;
    host_oe <= wr ? (width ? 16'hffff : 16'h00ff) : 16'h0000;
    lat = 0;
    do
    begin
      @(negedge clk);
      lat++;
    end
    while (!(ready_oe === 1'b1 && ready_n === 1'b0) && lat < 40);
    q = bus;
    q_oe = bus_oe;
    @(posedge clk);
    cs_n <= 1'b1;
    strb_n <= 1'b1;
    wr_n_dir <= 1'b1;
    host_oe <= 16'h0000;
    ale <= 1'b1;
    addr <= ~a;
    // Idle gap covers the commit cycle after a write
    repeat (3) @(posedge clk);
  endtask : access
endmodule : host_model
`default_nettype wire

//--- tb/async_host_register_port_tb.sv
// Self-checking bench for the parallel host register port.
// Assumes host_model is compiled first; unused data lines are pulled up.
`timescale 1ns/1ps
`default_nettype none
module async_host_register_port_tb;
  logic clk, sys_rst, rst_n, mode, width, swap, ale, cs_n, strb_n, wr_n_dir;
  logic ready_n, ready_oe, irq_n, irq_oe;
  logic [7:0] irq_event;
  logic [9:0] addr, a;
  logic [15:0] data_in, data_out, data_oe, host_d, host_oe, q, q_oe;
  logic [15:0] shadow [0:1023];
  int mismatches, checked, cycles, lat;
  // Weak pull-ups win only where nobody drives
  assign data_in = (data_oe & data_out) | (~data_oe & host_oe & host_d) | (~data_oe & ~host_oe);
  async_host_register_port u_dut (.clk(clk), .sys_rst(sys_rst), .rst_n(rst_n), .mode(mode),
    .width(width), .addr(addr), .byte_lane_swap(swap), .ale(ale), .cs_n(cs_n),
    .rd_n_data_strobe_n(strb_n), .wr_n_dir(wr_n_dir), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .ready_n(ready_n), .ready_oe(ready_oe), .irq_event(irq_event),
    .irq_n(irq_n), .irq_oe(irq_oe));
  host_model u_host (.clk(clk), .mode(mode), .width(width), .bus(data_in), .bus_oe(data_oe),
    .ready_n(ready_n), .ready_oe(ready_oe), .addr(addr), .byte_lane_swap(swap), .ale(ale),
    .cs_n(cs_n), .strb_n(strb_n), .wr_n_dir(wr_n_dir), .host_d(host_d), .host_oe(host_oe));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Checks and expectations
  // ----------------------------------------------------------------
  task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word
  task automatic check_flag(input string name, input logic exp, input logic got);
    check_word(name, {15'h0000, exp}, {15'h0000, got});
  endtask : check_flag
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  function automatic logic [15:0] exp_rd(logic [15:0] w, logic wd, logic a0);
    if (wd)
      return a0 ? {w[7:0], w[15:8]} : w;
    return {8'h00, a0 ? w[15:8] : w[7:0]};
  endfunction : exp_rd
  function automatic logic [15:0] upd(logic [15:0] w, logic [15:0] d, logic wd, logic a0);
    if (wd)
      return a0 ? {d[7:0], d[15:8]} : d;
    return a0 ? {d[7:0], w[7:0]} : {w[15:8], d[7:0]};
  endfunction : upd
  task automatic acc(input logic wr, input logic [9:0] ad, input logic a0, input logic [15:0] d,
    input logic muxed);
    u_host.access(wr, ad, a0, d, muxed, q, q_oe, lat);
    check_word("latency", wr ? 16'h0002 : 16'h0003, 16'(lat));
    if (wr)
      shadow[ad] = upd(shadow[ad], d, width, a0);
    else
    begin
      check_word("data oe", width ? 16'hffff : 16'h00ff, q_oe);
      check_word("rdata", exp_rd(shadow[ad], width, a0), q & q_oe);
    end
    @(negedge clk);
    check_word("idle oe", 16'h0000, data_oe);
    check_flag("idle ready oe", 1'b0, ready_oe);
  endtask : acc
  task automatic pulse_event;
    @(posedge clk);
    irq_event <= 8'h08;
    @(posedge clk);
    irq_event <= 8'h00;
    repeat (2) @(negedge clk);
  endtask : pulse_event
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    rst_n = 1'b1;
    mode = 1'b0;
    width = 1'b1;
    irq_event = 8'h00;
    mismatches = 0;
    checked = 0;
    cycles = 0;
    foreach (shadow[i])
      shadow[i] = 16'h0000;
    void'($urandom(50));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check_word("reset oe", 16'h0000, data_oe);
    pulse_event();
    check_flag("masked irq oe", 1'b0, irq_oe);
    acc(1'b1, 10'h001, 1'b0, 16'h0008, 1'b0);
    check_flag("irq oe", 1'b1, irq_oe);
    check_flag("irq level", 1'b0, irq_n);
    acc(1'b1, 10'h000, 1'b0, 16'h0008, 1'b0);
    check_flag("cleared irq oe", 1'b0, irq_oe);
    acc(1'b1, 10'h002, 1'b0, 16'h0001, 1'b0);
    check_flag("drive high oe", 1'b1, irq_oe);
    check_flag("drive high level", 1'b1, irq_n);
    pulse_event();
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    check_flag("reset pin irq oe", 1'b0, irq_oe);
    check_word("reset pin oe", 16'h0000, data_oe);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    shadow[1] = 16'h0000;
    acc(1'b0, 10'h001, 1'b0, 16'h0000, 1'b0);
    check_flag("irq oe after reset", 1'b0, irq_oe);
    // Top word written byte-wise in narrow mode, then read wide and swapped
    width <= 1'b0;
    acc(1'b1, 10'h3ff, 1'b1, 16'h00a5, 1'b0);
    width <= 1'b1;
    acc(1'b0, 10'h3ff, 1'b1, 16'h0000, 1'b1);
    repeat (40)
    begin
      mode <= 1'($urandom);
      width <= 1'($urandom);
      a = 10'(3 + $urandom % 4);
      acc(1'b1, a, 1'($urandom), 16'($urandom), 1'b0);
      width <= 1'($urandom);
      acc(1'b0, a, 1'($urandom), 16'h0000, 1'($urandom));
    end
    tally_and_finish();
  end
endmodule : async_host_register_port_tb
`default_nettype wire
